// ==== vpd_pkg.sv ====
// package: types and constants of the vliw packet dispatcher
// Functional notes
// - fetch fixed 256-bit packets of eight slots
// - lsb one chains next slot in
// - lsb zero ends packet, next issues later
// - one to eight slots, distinct units
// - one to eight packets per fetch
// - issue one execute packet per clock
// - fetch next only after all dispatched
// - two files of sixteen 32-bit registers
// - each side: logic, shift, multiply, address
// - own file serves all four units
// - one cross read and write per side
// - logic, shift, multiply units do float
// - double-word load, 64 bits per side
// - only address units touch data memory
// - address one file, data other file
// - linear or circular, 5/15-bit offsets
// - every instruction conditional on register
// - multiply units only multiply
// - logic, shift units: arithmetic, logic, branch
// - byte, half-word and word access
package vpd_pkg;
	localparam int SLOTS = 8;
	localparam int NREG = 16;
	localparam int FP_W = 256;
	localparam int IW = 32;
	localparam logic [31:0] PC_RESET = 32'h0000_0000;
	localparam logic [31:0] FP_STEP = 32'h0000_0020;
	localparam logic [31:0] FP_ALIGN = 32'hffff_ffe0;
	localparam logic [31:0] CIRC_MASK = 32'h0000_003f;
	localparam logic [3:0] BASE_REG = 4'hf;
	localparam logic [31:0] F_SIGN = 32'h8000_0000;
	localparam logic [30:0] F_INF = 31'h7f80_0000;
	localparam logic [9:0] FEXP_BIAS = 10'h07f;
	localparam logic [9:0] FEXP_MAX = 10'h0ff;
	localparam logic [1:0] K_L = 2'h0;
	localparam logic [1:0] K_S = 2'h1;
	localparam logic [1:0] K_M = 2'h2;
	localparam logic [1:0] K_D = 2'h3;
	localparam logic [3:0] OP_ADD = 4'h0;
	localparam logic [3:0] OP_SUB = 4'h1;
	localparam logic [3:0] OP_AND = 4'h2;
	localparam logic [3:0] OP_OR = 4'h3;
	localparam logic [3:0] OP_XOR = 4'h4;
	localparam logic [3:0] OP_SHL = 4'h5;
	localparam logic [3:0] OP_SHR = 4'h6;
	localparam logic [3:0] OP_BR = 4'h7;
	localparam logic [3:0] OP_FNEG = 4'h8;
	localparam logic [3:0] OP_FABS = 4'h9;
	localparam logic [3:0] OP_FCMPGT = 4'ha;
	localparam logic [3:0] OP_MPY = 4'h0;
	localparam logic [3:0] OP_FMPY = 4'h8;
	localparam int D_ST = 3;
	localparam int D_CIRC = 0;
	localparam logic [1:0] SZ_B = 2'h0;
	localparam logic [1:0] SZ_H = 2'h1;
	localparam logic [1:0] SZ_W = 2'h2;
	localparam logic [1:0] SZ_DW = 2'h3;

	typedef enum logic [1:0] {
		FS_REQ = 2'b00,
		FS_WAIT = 2'b01,
		FS_RUN = 2'b10
	} vpd_fst_t;

	typedef struct packed {
		logic [4:0] ext;
		logic xl;
		logic [4:0] s2;
		logic z;
		logic [2:0] creg;
		logic x;
		logic [3:0] s1;
		logic [3:0] dst;
		logic [3:0] op;
		logic [2:0] unit;
		logic p;
	} vpd_instr_t;

	typedef struct packed {
		logic vld;
		vpd_instr_t ins;
	} vpd_issue_t;

	typedef struct packed {
		logic we;
		logic xw;
		logic [3:0] dst;
		logic [31:0] data;
		logic br;
		logic [31:0] tgt;
	} vpd_res_t;

	typedef struct packed {
		logic vld;
		logic we;
		logic [1:0] sz;
		logic [31:0] addr;
		logic [31:0] wdata;
	} vpd_mreq_t;

	typedef struct packed {
		logic vld;
		logic dw;
		logic [1:0] sz;
		logic sd;
		logic [3:0] dst;
	} vpd_ld_t;
endpackage

// ==== vpd_unit.sv ====
// one functional unit: alu, multiplier or address generator
`timescale 1ns/100ps
module vpd_unit #(
	parameter logic [1:0] KIND = 2'h0
) (
	input wire logic ena,
	input vpd_pkg::vpd_instr_t ins,
	input wire logic [31:0] opa,
	input wire logic [31:0] opb,
	input wire logic [31:0] base,
	input wire logic [31:0] sdat,
	output vpd_pkg::vpd_res_t res,
	output vpd_pkg::vpd_mreq_t mrq
);
	logic [47:0] fm;
	logic [9:0] fe;
	logic fsg;
	logic [31:0] fmul, mlo, alu, mres, key_a, key_b;
	logic [31:0] off, bse, lin, addr;
	logic is_br, m_ok;

	assign key_a = opa[31] ? ~opa : (opa | vpd_pkg::F_SIGN);
	assign key_b = opb[31] ? ~opb : (opb | vpd_pkg::F_SIGN);
	assign is_br = (KIND == vpd_pkg::K_L || KIND == vpd_pkg::K_S) &&
		ins.op == vpd_pkg::OP_BR;

	always_comb begin
		case (ins.op)
		vpd_pkg::OP_ADD: alu = opa + opb;
		vpd_pkg::OP_SUB: alu = opa - opb;
		vpd_pkg::OP_AND: alu = opa & opb;
		vpd_pkg::OP_OR: alu = opa | opb;
		vpd_pkg::OP_XOR: alu = opa ^ opb;
		vpd_pkg::OP_SHL: alu = opa << opb[4:0];
		vpd_pkg::OP_SHR: alu = $signed(opa) >>> opb[4:0];
		vpd_pkg::OP_FNEG: alu = opa ^ vpd_pkg::F_SIGN;
		vpd_pkg::OP_FABS: alu = opa & ~vpd_pkg::F_SIGN;
		vpd_pkg::OP_FCMPGT: alu = {31'h0, key_a > key_b};
		default: alu = 32'h0;
		endcase
	end

	// single precision multiply, truncating; denormals flush to zero
	assign fsg = opa[31] ^ opb[31];
	assign fm = {1'b1, opa[22:0]} * {1'b1, opb[22:0]};
	assign fe = {2'h0, opa[30:23]} + {2'h0, opb[30:23]} -
		vpd_pkg::FEXP_BIAS + {9'h0, fm[47]};
	always_comb begin
		if (opa[30:23] == 8'h0 || opb[30:23] == 8'h0 || fe[9] || fe == 10'h0)
			fmul = {fsg, 31'h0};
		else if (fe >= vpd_pkg::FEXP_MAX)
			fmul = {fsg, vpd_pkg::F_INF};
		else
			fmul = {fsg, fe[7:0], fm[47] ? fm[46:24] : fm[45:23]};
	end
	assign mlo = opa * opb;
	assign mres = (ins.op == vpd_pkg::OP_FMPY) ? fmul : mlo;
	assign m_ok = ins.op == vpd_pkg::OP_MPY || ins.op == vpd_pkg::OP_FMPY;

	always_comb begin
		res.we = ena && KIND != vpd_pkg::K_D && !is_br &&
			(KIND != vpd_pkg::K_M || m_ok);
		res.xw = ins.xl;
		res.dst = ins.dst;
		res.data = (KIND == vpd_pkg::K_M) ? mres : alu;
		res.br = ena && is_br;
		res.tgt = opa;
	end

	// long form uses the fixed base register and a 15-bit offset
	assign off = ins.xl ? {17'h0, ins.ext, ins.s2, ins.s1, ins.x} :
		{27'h0, ins.s2};
	assign bse = ins.xl ? base : opa;
	assign lin = bse + off;
	assign addr = ins.op[vpd_pkg::D_CIRC] ?
		((bse & ~vpd_pkg::CIRC_MASK) | (lin & vpd_pkg::CIRC_MASK)) : lin;
	assign mrq = '{vld: ena && KIND == vpd_pkg::K_D,
		we: ins.op[vpd_pkg::D_ST], sz: ins.op[2:1], addr: addr,
		wdata: sdat};
endmodule

// ==== vpd_dispatch.sv ====
// fetch, packet split, dispatch and two-sided register datapath
`timescale 1ns/100ps
module vpd_dispatch (
	input wire logic clk,
	input wire logic reset_n,
	output logic fetch_req,
	output logic [31:0] fetch_addr,
	input wire logic fetch_gnt,
	input wire logic fetch_vld,
	input wire logic [255:0] fetch_data,
	output vpd_pkg::vpd_mreq_t dmem_a,
	input wire logic [63:0] dmem_a_rdata,
	output vpd_pkg::vpd_mreq_t dmem_b,
	input wire logic [63:0] dmem_b_rdata,
	output logic [7:0] unit_issued,
	output logic unit_clash
);
	vpd_pkg::vpd_fst_t st_r, st_nxt;
	logic [31:0] pc_r, pc_nxt;
	logic [2:0] ptr_r, ptr_nxt;
	logic drop_r, drop_nxt;
	logic ld_fp;
	vpd_pkg::vpd_instr_t [vpd_pkg::SLOTS-1:0] fp_r;
	vpd_pkg::vpd_issue_t iss_r [vpd_pkg::SLOTS];
	vpd_pkg::vpd_issue_t iss_nxt [vpd_pkg::SLOTS];
	logic clash_r, clash_nxt;

	logic [31:0] rf_r [2][vpd_pkg::NREG];
	vpd_pkg::vpd_mreq_t dm_r [2];
	vpd_pkg::vpd_ld_t ld_r [2];
	logic [63:0] rdat [2];

	logic [7:0] brk, nop, ep_m;
	logic [2:0] ep_last;
	logic fp_done;

	vpd_pkg::vpd_res_t res [vpd_pkg::SLOTS];
	vpd_pkg::vpd_mreq_t mrq [vpd_pkg::SLOTS];
	logic [31:0] opa [vpd_pkg::SLOTS];
	logic [31:0] opb [vpd_pkg::SLOTS];
	logic [31:0] osd [vpd_pkg::SLOTS];
	logic [3:0] xad [vpd_pkg::SLOTS];
	logic [3:0] xa [2];
	logic [31:0] xbus [2];
	logic [7:0] xrq, cok, wen, wsd;
	logic br_any;
	logic [31:0] br_tgt;

	// slot decode: chain bit and padding
	for (genvar j = 0; j < vpd_pkg::SLOTS; j++) begin : g_slot
		assign brk[j] = !fp_r[j].p || (j == vpd_pkg::SLOTS - 1);
		assign nop[j] = fp_r[j][31:1] == 31'h0;
	end

	// execute packet: from the pointer up to the first slot that breaks
	always_comb begin
		logic open;
		open = 1'b0;
		ep_m = 8'h00;
		ep_last = 3'h7;
		for (int j = 0; j < vpd_pkg::SLOTS; j++) begin
			if (3'(j) == ptr_r)
				open = 1'b1;
			if (open)
				ep_m[j] = 1'b1;
			if (open && brk[j]) begin
				ep_last = 3'(j);
				open = 1'b0;
			end
		end
	end
	assign fp_done = ep_last == 3'h7;

	// route each slot to the unit its field names; a repeat is dropped
	always_comb begin
		clash_nxt = 1'b0;
		for (int u = 0; u < vpd_pkg::SLOTS; u++)
			iss_nxt[u] = '0;
		if (st_r == vpd_pkg::FS_RUN) begin
			for (int j = 0; j < vpd_pkg::SLOTS; j++) begin
				for (int u = 0; u < vpd_pkg::SLOTS; u++) begin
					if (ep_m[j] && !nop[j] && fp_r[j].unit == 3'(u)) begin
						if (iss_nxt[u].vld)
							clash_nxt = 1'b1;
						else
							iss_nxt[u] = '{vld: 1'b1, ins: fp_r[j]};
					end
				end
			end
		end
	end

	// first branch in unit order wins
	always_comb begin
		br_any = 1'b0;
		br_tgt = 32'h0;
		for (int u = vpd_pkg::SLOTS - 1; u >= 0; u--) begin
			if (res[u].br) begin
				br_any = 1'b1;
				br_tgt = res[u].tgt;
			end
		end
	end

	always_comb begin
		st_nxt = st_r;
		pc_nxt = pc_r;
		ptr_nxt = ptr_r;
		drop_nxt = drop_r;
		ld_fp = 1'b0;
		case (st_r)
		vpd_pkg::FS_REQ: begin
			if (fetch_gnt)
				st_nxt = vpd_pkg::FS_WAIT;
		end
		vpd_pkg::FS_WAIT: begin
			if (fetch_vld) begin
				st_nxt = drop_r ? vpd_pkg::FS_REQ : vpd_pkg::FS_RUN;
				ld_fp = !drop_r;
				drop_nxt = 1'b0;
				ptr_nxt = 3'h0;
			end
		end
		vpd_pkg::FS_RUN: begin
			ptr_nxt = ep_last + 3'h1;
			if (fp_done) begin
				st_nxt = vpd_pkg::FS_REQ;
				pc_nxt = pc_r + vpd_pkg::FP_STEP;
			end
		end
		default: st_nxt = vpd_pkg::FS_REQ;
		endcase
		// a fetch already in flight on the old path is discarded
		if (br_any) begin
			pc_nxt = br_tgt & vpd_pkg::FP_ALIGN;
			drop_nxt = st_nxt == vpd_pkg::FS_WAIT;
			if (st_nxt == vpd_pkg::FS_RUN)
				st_nxt = vpd_pkg::FS_REQ;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st_r <= vpd_pkg::FS_REQ;
			pc_r <= vpd_pkg::PC_RESET;
			ptr_r <= 3'h0;
			drop_r <= 1'b0;
			clash_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			pc_r <= pc_nxt;
			ptr_r <= ptr_nxt;
			drop_r <= drop_nxt;
			clash_r <= clash_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (ld_fp)
			fp_r <= fetch_data;
	end

	always_ff @(posedge clk) begin
		for (int u = 0; u < vpd_pkg::SLOTS; u++)
			iss_r[u] <= reset_n ? iss_nxt[u] : '0;
	end

	// operand access, one unit per generate entry
	for (genvar u = 0; u < vpd_pkg::SLOTS; u++) begin : g_u
		localparam int SD = u / 4;
		localparam int KD = u % 4;
		vpd_pkg::vpd_instr_t ins;
		logic [31:0] cv;
		assign ins = iss_r[u].ins;
		assign xrq[u] = iss_r[u].vld && ins.x && !(KD == 3 && ins.xl);
		assign xad[u] = (KD == 3) ? ins.dst : ins.s2[3:0];
		assign opa[u] = rf_r[SD][ins.s1];
		assign opb[u] = xrq[u] ? xbus[SD] : rf_r[SD][ins.s2[3:0]];
		assign osd[u] = xrq[u] ? xbus[SD] : rf_r[SD][ins.dst];
		assign cv = rf_r[ins.creg[2]][{2'b00, ins.creg[1:0]}];
		assign cok[u] = ins.creg == 3'h0 ||
			(ins.z ? cv == 32'h0 : cv != 32'h0);
		assign wsd[u] = 1'(SD) ^ res[u].xw;
		vpd_unit #(
			.KIND(2'(KD))
		) u_unit (
			.ena(iss_r[u].vld && cok[u]),
			.ins(ins),
			.opa(opa[u]),
			.opb(opb[u]),
			.base(rf_r[SD][vpd_pkg::BASE_REG]),
			.sdat(osd[u]),
			.res(res[u]),
			.mrq(mrq[u])
		);
	end

	// one cross bus per side; every requester sees the first one's read
	always_comb begin
		for (int s = 0; s < 2; s++) begin
			xa[s] = 4'h0;
			for (int k = 3; k >= 0; k--)
				if (xrq[4 * s + k])
					xa[s] = xad[4 * s + k];
		end
	end
	assign xbus[0] = rf_r[1][xa[0]];
	assign xbus[1] = rf_r[0][xa[1]];

	// one cross write per side; later cross writers are suppressed
	always_comb begin
		logic [1:0] used;
		used = 2'b00;
		for (int u = 0; u < vpd_pkg::SLOTS; u++) begin
			wen[u] = res[u].we && !(res[u].xw && used[u / 4]);
			if (res[u].we && res[u].xw)
				used[u / 4] = 1'b1;
		end
	end

	function automatic logic [31:0] ld_ext(logic [1:0] sz, logic [31:0] d);
		case (sz)
		vpd_pkg::SZ_B: ld_ext = {{24{d[7]}}, d[7:0]};
		vpd_pkg::SZ_H: ld_ext = {{16{d[15]}}, d[15:0]};
		default: ld_ext = d;
		endcase
	endfunction

	assign rdat[0] = dmem_a_rdata;
	assign rdat[1] = dmem_b_rdata;

	// load results land after unit results so a load wins a collision
	always_ff @(posedge clk) begin
		for (int u = 0; u < vpd_pkg::SLOTS; u++)
			if (wen[u])
				rf_r[wsd[u]][res[u].dst] <= res[u].data;
		for (int s = 0; s < 2; s++) begin
			if (ld_r[s].vld && ld_r[s].dw) begin
				rf_r[ld_r[s].sd][{ld_r[s].dst[3:1], 1'b0}] <= rdat[s][31:0];
				rf_r[ld_r[s].sd][{ld_r[s].dst[3:1], 1'b1}] <= rdat[s][63:32];
			end else if (ld_r[s].vld) begin
				rf_r[ld_r[s].sd][ld_r[s].dst] <= ld_ext(ld_r[s].sz, rdat[s][31:0]);
			end
		end
	end

	// only the two address units reach data memory
	always_ff @(posedge clk) begin
		for (int s = 0; s < 2; s++) begin
			if (!reset_n) begin
				dm_r[s] <= '0;
				ld_r[s] <= '0;
			end else begin
				dm_r[s] <= mrq[4 * s + 3];
				ld_r[s] <= '{vld: mrq[4 * s + 3].vld && !mrq[4 * s + 3].we,
					dw: mrq[4 * s + 3].sz == vpd_pkg::SZ_DW,
					sz: mrq[4 * s + 3].sz,
					sd: 1'(s) ^ xrq[4 * s + 3],
					dst: iss_r[4 * s + 3].ins.dst};
			end
		end
	end

	assign fetch_req = st_r == vpd_pkg::FS_REQ;
	assign fetch_addr = pc_r;
	assign dmem_a = dm_r[0];
	assign dmem_b = dm_r[1];
	assign unit_clash = clash_r;
	for (genvar u = 0; u < vpd_pkg::SLOTS; u++) begin : g_out
		assign unit_issued[u] = iss_r[u].vld;
	end
endmodule

// ==== vpd_dispatch_monitor.sv ====
// concurrent checks on the ports of the packet dispatcher
`timescale 1ns/100ps
module vpd_dispatch_monitor (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic fetch_req,
	input wire logic [31:0] fetch_addr,
	input wire logic fetch_gnt,
	input wire logic fetch_vld,
	input vpd_pkg::vpd_mreq_t dmem_a,
	input vpd_pkg::vpd_mreq_t dmem_b,
	input wire logic [7:0] unit_issued,
	input wire logic unit_clash
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_req_holds: assert property (fetch_req && !fetch_gnt |=> fetch_req)
		else $error("fetch request dropped before its grant");
	a_gnt_ends_req: assert property (fetch_req && fetch_gnt |=> !fetch_req)
		else $error("fetch request still up after its grant");
	// nothing issues and nothing is asked while one fetch is outstanding
	a_wait_quiet: assert property (fetch_req && fetch_gnt |=>
		(!fetch_req && unit_issued == 8'h00) until fetch_vld)
		else $error("activity while a fetch is outstanding");
	a_addr_aligned: assert property (fetch_req |-> fetch_addr[4:0] == 5'h00)
		else $error("fetch address not on a packet boundary");
	a_data_runs: assert property (fetch_vld |=> !fetch_req)
		else $error("new fetch before any packet was dispatched");
	a_clash_issue: assert property (unit_clash |-> unit_issued != 8'h00)
		else $error("clash flagged without an issued packet");
	a_mem_a_cause: assert property (dmem_a.vld |-> $past(unit_issued[3]))
		else $error("side a memory access without its address unit");
	a_mem_b_cause: assert property (dmem_b.vld |-> $past(unit_issued[7]))
		else $error("side b memory access without its address unit");
endmodule

bind vpd_dispatch vpd_dispatch_monitor i_vpd_dispatch_monitor (
	.clk(clk),
	.reset_n(reset_n),
	.fetch_req(fetch_req),
	.fetch_addr(fetch_addr),
	.fetch_gnt(fetch_gnt),
	.fetch_vld(fetch_vld),
	.dmem_a(dmem_a),
	.dmem_b(dmem_b),
	.unit_issued(unit_issued),
	.unit_clash(unit_clash)
);

// ==== vpd_pmem.sv ====
// program memory model answering fetch requests with whole packets
`timescale 1ns/100ps
module vpd_pmem (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic fetch_req,
	input wire logic [31:0] fetch_addr,
	output logic fetch_gnt,
	output logic fetch_vld,
	output logic [255:0] fetch_data
);
	logic [255:0] mem [0:7];
	logic busy_r;
	logic [2:0] idx_r;
	logic [2:0] lat_r;
	logic [1:0] wait_r;
	logic deliver;
	int n_gnt;

	// odd packets answer slowly so both the stalled and prompt paths run
	assign fetch_gnt = fetch_req && !busy_r && (!fetch_addr[5] || wait_r == 2'h3);

	assign deliver = reset_n && busy_r && lat_r == 3'h0;

	// data lines toggle outside the valid pulse so stale data never looks good
	always @(posedge clk) begin
		fetch_vld <= deliver;
		if (deliver)
			fetch_data <= mem[idx_r];
		else
			fetch_data <= reset_n ? ~fetch_data : 256'h0;
	end

	always @(posedge clk) begin
		if (!reset_n) begin
			busy_r <= 1'b0;
			wait_r <= 2'h0;
			n_gnt <= 0;
		end else if (fetch_gnt) begin
			busy_r <= 1'b1;
			idx_r <= fetch_addr[7:5];
			lat_r <= fetch_addr[5] ? 3'h4 : 3'h0;
			wait_r <= 2'h0;
			n_gnt <= n_gnt + 1;
		end else if (busy_r && lat_r != 3'h0) begin
			lat_r <= lat_r - 3'h1;
		end else if (busy_r) begin
			busy_r <= 1'b0;
		end else if (fetch_req) begin
			wait_r <= wait_r + 2'h1;
		end
	end
endmodule

// ==== vpd_dispatch_tb_top.sv ====
// self-checking bench for the packet dispatcher
`timescale 1ns/100ps
module vpd_dispatch_tb_top;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic fetch_req;
	logic fetch_gnt;
	logic fetch_vld;
	logic unit_clash;
	logic [31:0] fetch_addr;
	logic [255:0] fetch_data;
	logic [63:0] dmem_a_rdata = 64'h0123_4567_89ab_cdef;
	logic [63:0] dmem_b_rdata = 64'hfedc_ba98_7654_3210;
	vpd_pkg::vpd_mreq_t dmem_a;
	vpd_pkg::vpd_mreq_t dmem_b;
	logic [7:0] unit_issued;
	logic [7:0][31:0] w_full;
	logic [7:0][31:0] w_each;
	int num_errors = 0;
	int checked = 0;

	always #50 clk = ~clk;

	vpd_dispatch i_vpd_dispatch (
		.clk(clk),
		.reset_n(reset_n),
		.fetch_req(fetch_req),
		.fetch_addr(fetch_addr),
		.fetch_gnt(fetch_gnt),
		.fetch_vld(fetch_vld),
		.fetch_data(fetch_data),
		.dmem_a(dmem_a),
		.dmem_a_rdata(dmem_a_rdata),
		.dmem_b(dmem_b),
		.dmem_b_rdata(dmem_b_rdata),
		.unit_issued(unit_issued),
		.unit_clash(unit_clash)
	);

	vpd_pmem i_vpd_pmem (
		.clk(clk),
		.reset_n(reset_n),
		.fetch_req(fetch_req),
		.fetch_addr(fetch_addr),
		.fetch_gnt(fetch_gnt),
		.fetch_vld(fetch_vld),
		.fetch_data(fetch_data)
	);

	// dst 1 keeps a unit 0 add from reading as a nop
	function automatic logic [31:0] mk(input logic [2:0] u, input logic p);
		return {20'h0_0000, 4'h1, 4'h0, u, p};
	endfunction

	// fields: unit, op, dst, src1, src2 or offset, cross, chain
	function automatic logic [31:0] mi(input logic [2:0] u,
		input logic [3:0] op, input logic [3:0] d, input logic [3:0] s1,
		input logic [4:0] s2, input logic x, input logic p);
		return {6'h00, s2, 4'h0, x, s1, d, op, u, p};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// exp entries are {clash, issued units}, one per cycle, no fetch between
	task automatic run_fp(input string name, input logic [31:0] addr,
		input logic [8:0] exp[$]);
		int n;
		int g;
		n = 0;
		while (!(fetch_req === 1'b1 && fetch_gnt === 1'b1) && n < 40) begin
			@(negedge clk);
			n++;
		end
		chk(fetch_addr, addr, "fetch address");
		g = i_vpd_pmem.n_gnt + 1;
		n = 0;
		@(negedge clk);
		while (unit_issued === 8'h00 && n < 40) begin
			@(negedge clk);
			n++;
		end
		foreach (exp[i]) begin
			if (i > 0)
				@(negedge clk);
			chk({23'h0, unit_clash, unit_issued}, {23'h0, exp[i]}, "issue");
			chk(32'(i_vpd_pmem.n_gnt), 32'(g), "fetch count");
		end
		$display("test %s done", name);
	endtask

	task automatic t_reset;
		repeat (3) @(negedge clk);
		chk(fetch_addr, 32'h0, "reset address");
		chk({20'h0, fetch_req, unit_clash, dmem_a.vld, dmem_b.vld,
			unit_issued},
			32'h0000_0800, "reset outputs");
		$display("test reset done");
	endtask

	task automatic t_chain;
		run_fp("chain", 32'h0, {9'h005, 9'h032, 9'h040, 9'h088});
	endtask

	task automatic t_full;
		run_fp("full", 32'h20, {9'h0ff});
	endtask

	task automatic t_eight;
		run_fp("eight", 32'h40, {9'h001, 9'h002, 9'h004, 9'h008,
			9'h010, 9'h020, 9'h040, 9'h080});
	endtask

	task automatic t_pad;
		run_fp("pad", 32'h60, {9'h020, 9'h000, 9'h000, 9'h000,
			9'h000, 9'h000, 9'h000, 9'h000});
	endtask

	task automatic t_clash;
		run_fp("clash", 32'h80, {9'h102});
	endtask

	// loads fill a2/a3 and b2/b3; stores then show a2, a3 and b3 on the data ports
	task automatic t_mem;
		run_fp("mem", 32'ha0, {9'h088, 9'h000, 9'h089, 9'h008});
		chk({28'h0, dmem_a.vld, dmem_a.we, dmem_a.sz}, 32'he, "a kind");
		chk(dmem_a.addr, 32'h0123_456b, "a address");
		chk(dmem_a.wdata, 32'h89ab_cdef, "a data");
		chk({28'h0, dmem_b.vld, dmem_b.we, dmem_b.sz}, 32'he, "b kind");
		chk(dmem_b.addr, 32'hfedc_ba98, "b address");
		chk(dmem_b.wdata, 32'h89ab_cdef, "b cross data");
		@(negedge clk);
		chk({23'h0, unit_clash, unit_issued}, 32'h0, "pad issue");
		chk(dmem_a.addr, 32'h0123_4567, "a add address");
		chk(dmem_a.wdata, 32'h8acf_1356, "add result");
		chk({31'h0, dmem_b.vld}, 32'h0, "b idle");
		$display("test mem stores done");
	endtask

	initial begin
		for (int k = 0; k < 8; k++) begin
			i_vpd_pmem.mem[k] = 256'h0;
			w_full[k] = mk(3'(k), 1'b1);
			w_each[k] = mk(3'(k), 1'b0);
		end
		i_vpd_pmem.mem[0] = {mk(3'h7, 1'b0), mk(3'h3, 1'b1), mk(3'h6, 1'b0),
			mk(3'h5, 1'b0), mk(3'h4, 1'b1), mk(3'h1, 1'b1), mk(3'h2, 1'b0),
			mk(3'h0, 1'b1)};
		i_vpd_pmem.mem[1] = w_full;
		i_vpd_pmem.mem[2] = w_each;
		i_vpd_pmem.mem[3] = {224'h0, mk(3'h5, 1'b0)};
		i_vpd_pmem.mem[4] = {192'h0, mk(3'h1, 1'b0), mk(3'h1, 1'b1)};
		i_vpd_pmem.mem[5] = {32'h0,
			mi(3'h3, 4'hc, 4'h4, 4'h3, 5'h00, 1'b0, 1'b0),
			mi(3'h0, 4'h0, 4'h4, 4'h2, 5'h03, 1'b0, 1'b0),
			mi(3'h7, 4'hc, 4'h2, 4'h3, 5'h00, 1'b1, 1'b1),
			mi(3'h3, 4'hc, 4'h2, 4'h3, 5'h04, 1'b0, 1'b1),
			32'h0,
			mi(3'h7, 4'h6, 4'h2, 4'h0, 5'h00, 1'b0, 1'b0),
			mi(3'h3, 4'h6, 4'h2, 4'h0, 5'h00, 1'b0, 1'b1)};
		t_reset;
		repeat (17) @(posedge clk);
		reset_n <= 1'b1;
		@(negedge clk);
		t_chain;
		t_full;
		t_eight;
		t_pad;
		t_clash;
		t_mem;
		complete_run;
	end

	// the whole sequence needs about a hundred cycles
	initial begin
		repeat (2000) @(posedge clk);
		num_errors++;
		$display("Error at %0t: run did not finish", $time);
		complete_run;
	end
endmodule
